// ### include/ccc_defs.svh
`ifndef CCC_DEFS_SVH
`define CCC_DEFS_SVH
`define CCC_ADDR_CTRL 4'h0
`define CCC_ADDR_FAST_CHARGE_CURRENT_FIELD 4'h1
`define CCC_ADDR_IPRE 4'h2
`define CCC_ADDR_VREG 4'h3
`define CCC_ADDR_STAT 4'h4
`define CCC_ADDR_TMR 4'h5
`define CCC_CTRL_RST 8'h01
`define CCC_FAST_CHARGE_CURRENT_FIELD_RST 8'h20
`define CCC_IPRE_RST 8'h04
`define CCC_VREG_RST 8'h48
`define CCC_VREG_MAX 8'h73
`define CCC_TMR_RST 16'h1000
`define CCC_STAT_IDLE 2'h0
`define CCC_STAT_PRE 2'h1
`define CCC_STAT_FAST 2'h2
`define CCC_STAT_DONE 2'h3
`define CCC_SEL_OFF 3'h0
`define CCC_SEL_TRICKLE 3'h1
`define CCC_SEL_PRE 3'h2
`define CCC_SEL_FAST 3'h3
`define CCC_SEL_CV 3'h4
`endif

// ### include/ccc_pkg.sv
package ccc_pkg;
  typedef enum logic [6:0] {
    CCC_IDLE = 7'h01,
    CCC_TRICKLE = 7'h02,
    CCC_PRE = 7'h04,
    CCC_CC = 7'h08,
    CCC_CV = 7'h10,
    CCC_DONE = 7'h20,
    CCC_FAULT = 7'h40
  } ccc_state_t;
  typedef struct packed {
    logic in_uvlo_ok;
    logic in_above_bat;
    logic in_below_ovp;
    logic bat_above_sc;
    logic bat_above_lowv;
    logic bat_at_reg;
    logic bat_below_rechg;
    logic bat_above_depl;
    logic cur_at_term;
    logic input_voltage_limit_loop_act;
    logic power_path_droop_loop_act;
    logic input_current_limit_loop_act;
    logic therm_act;
    logic ts_fault;
    logic supplement_act;
  } ccc_flags_t;
  typedef struct packed {
    ccc_state_t state;
    ccc_flags_t s1;
    ccc_flags_t s2;
    logic ce_n_s1;
    logic ce_n_s2;
    logic [7:0] ctrl;
    logic [7:0] fast_charge_current_field;
    logic [7:0] ipre;
    logic [7:0] vreg;
    logic [15:0] tmr_limit;
    logic [17:0] tmr_cnt;
    logic tmr_tick;
    logic [7:0] rdata;
    logic fet_on;
    logic [2:0] sel;
    logic [7:0] itarget;
    logic [7:0] vtarget;
    logic tmr_run;
    logic [1:0] stat;
    logic sys_from_bat;
    logic expired;
  } ccc_regs_t;
endpackage

// ### rtl/ccc_top.sv
// Behaviour
// RULE_01 - Charge only while input is valid.
// RULE_02 - Disable bit or pin high opens switch.
// RULE_03 - Below short-circuit threshold use trickle current.
// RULE_04 - Precharge timer is quarter of fast.
// RULE_05 - Between thresholds use programmed precharge current.
// RULE_06 - Above low threshold go fast charge.
// RULE_07 - No termination: precharge is fifth of fast.
// RULE_08 - Constant current unless fault or loop limits.
// RULE_09 - At regulation voltage hand to voltage loop.
// RULE_10 - Taper to termination sets done status.
// RULE_11 - Clamp regulation target to top code.
// RULE_12 - Host programs fast-charge current field.
// RULE_13 - After done switch off, rail from input.
// RULE_14 - Terminate only in constant-voltage loop.
// RULE_15 - Limiting loops suppress termination.
// RULE_16 - Falling to recharge threshold restarts cycle.
// RULE_17 - Restart resets all safety timers.
// RULE_18 - Battery may supplement rail always.
// RULE_19 - Input gone, battery above depletion, feeds rail.
// RULE_20 - All loops enabled while charging.
// RULE_21 - Input limiting with enable doubles timer.
// RULE_22 - Supplement mode blocks termination.
// RULE_23 - Flags synchronised into one state machine.
// RULE_24 - Timer expiry stops charging until restart.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "ccc_defs.svh"
module ccc_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Analog comparator flags and pin
  input wire ccc_pkg::ccc_flags_t FLAGS,
  input wire logic CHARGE_ENABLE_N,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Charger controls
  output logic BATTERY_SWITCH,
  output logic [2:0] CURRENT_SELECT,
  output logic [7:0] CURRENT_TARGET,
  output logic [7:0] VOLTAGE_TARGET,
  output logic LOOPS_ENABLE,
  output logic TIMER_RUN,
  output logic [1:0] CHARGE_STATE,
  output logic SYSTEM_FROM_BATTERY
);
  import ccc_pkg::*;
  // ctrl bits: 0 charge_disable_bit, 1 trickle_current_select, 2 timer_double_enable,
  // 3 termination enable (active low: bit set disables termination).
  ccc_regs_t r_ff;
  ccc_regs_t nxt_r;
  logic in_valid;
  logic enabled;
  logic term_ok;
  logic [17:0] limit;
  logic [7:0] fifth;
  logic tmr_hit;

  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.s1 = FLAGS; // RULE_23
    nxt_r.s2 = r_ff.s1;
    nxt_r.ce_n_s1 = CHARGE_ENABLE_N;
    nxt_r.ce_n_s2 = r_ff.ce_n_s1;
    in_valid = r_ff.s2.in_uvlo_ok && r_ff.s2.in_above_bat && r_ff.s2.in_below_ovp; // RULE_01
    enabled = in_valid && !r_ff.ctrl[0] && !r_ff.ce_n_s2; // RULE_02
    // Termination needs the voltage loop and none of the limiting loops or supplement.
    term_ok = r_ff.s2.cur_at_term && !r_ff.ctrl[3] && !r_ff.s2.input_voltage_limit_loop_act
      && !r_ff.s2.power_path_droop_loop_act && !r_ff.s2.input_current_limit_loop_act && !r_ff.s2.therm_act
      && !r_ff.s2.supplement_act; // RULE_15 RULE_22
    // Limit in clock cycles; precharge phases get a quarter, input limiting may double it.
    limit = {2'h0, r_ff.tmr_limit};
    if (r_ff.state == CCC_TRICKLE || r_ff.state == CCC_PRE)
    begin
      limit = {4'h0, r_ff.tmr_limit[15:2]}; // RULE_04
    end
    if (r_ff.s2.input_voltage_limit_loop_act && r_ff.ctrl[2])
    begin
      limit = {limit[16:0], 1'b0}; // RULE_21
    end
    tmr_hit = r_ff.tmr_cnt >= limit;
    fifth = 8'((16'(r_ff.fast_charge_current_field) * 16'h0033) >> 8); // RULE_07
    if (r_ff.tmr_run)
    begin
      nxt_r.tmr_cnt = r_ff.tmr_cnt + 18'h0_0001;
    end
    case (r_ff.state)
      CCC_IDLE:
      begin
        nxt_r.tmr_cnt = 18'h0_0000;
        if (enabled)
        begin
          nxt_r.state = CCC_TRICKLE;
        end
      end
      CCC_TRICKLE, CCC_PRE, CCC_CC, CCC_CV:
      begin
        if (!enabled)
        begin
          nxt_r.state = CCC_IDLE; // RULE_02
        end
        else if (tmr_hit)
        begin
          nxt_r.state = CCC_FAULT; // RULE_24
        end
        else if (!r_ff.s2.bat_above_sc)
        begin
          nxt_r.state = CCC_TRICKLE; // RULE_03
        end
        else if (!r_ff.s2.bat_above_lowv)
        begin
          nxt_r.state = CCC_PRE; // RULE_05
        end
        else if (r_ff.state == CCC_CV)
        begin
          if (term_ok)
          begin
            nxt_r.state = CCC_DONE; // RULE_10 RULE_14
          end
        end
        else if (r_ff.s2.bat_at_reg)
        begin
          nxt_r.state = CCC_CV; // RULE_09
        end
        else
        begin
          if (r_ff.state != CCC_CC)
          begin
            nxt_r.tmr_cnt = 18'h0_0000;
          end
          nxt_r.state = CCC_CC; // RULE_06
        end
      end
      CCC_DONE:
      begin
        if (!enabled)
        begin
          nxt_r.state = CCC_IDLE;
        end
        else if (r_ff.s2.bat_below_rechg)
        begin
          nxt_r.tmr_cnt = 18'h0_0000; // RULE_17
          nxt_r.state = CCC_TRICKLE; // RULE_16
        end
      end
      CCC_FAULT:
      begin
        if (!enabled)
        begin
          nxt_r.state = CCC_IDLE; // RULE_24
        end
      end
      default:
      begin
        nxt_r.state = CCC_IDLE;
      end
    endcase
    // Outputs follow the next state so they line up with it.
    nxt_r.tmr_run = 1'b0;
    nxt_r.fet_on = 1'b0;
    nxt_r.sel = `CCC_SEL_OFF;
    nxt_r.itarget = 8'h00;
    nxt_r.stat = `CCC_STAT_IDLE;
    case (nxt_r.state)
      CCC_TRICKLE:
      begin
        nxt_r.fet_on = 1'b1;
        nxt_r.tmr_run = 1'b1;
        nxt_r.sel = `CCC_SEL_TRICKLE; // RULE_03
        nxt_r.itarget = r_ff.ctrl[1] ? 8'h08 : 8'h01;
        nxt_r.stat = `CCC_STAT_PRE;
      end
      CCC_PRE:
      begin
        nxt_r.fet_on = 1'b1;
        nxt_r.tmr_run = 1'b1;
        nxt_r.sel = `CCC_SEL_PRE;
        nxt_r.itarget = r_ff.ctrl[3] ? fifth : r_ff.ipre; // RULE_05 RULE_07
        nxt_r.stat = `CCC_STAT_PRE;
      end
      CCC_CC:
      begin
        nxt_r.fet_on = 1'b1;
        nxt_r.tmr_run = 1'b1;
        nxt_r.sel = `CCC_SEL_FAST;
        // The analog loops cut current below target; the target itself stays full.
        nxt_r.itarget = r_ff.fast_charge_current_field; // RULE_08 RULE_12
        nxt_r.stat = `CCC_STAT_FAST;
      end
      CCC_CV:
      begin
        nxt_r.fet_on = 1'b1;
        nxt_r.tmr_run = 1'b1;
        nxt_r.sel = `CCC_SEL_CV; // RULE_09
        nxt_r.itarget = r_ff.fast_charge_current_field;
        nxt_r.stat = `CCC_STAT_FAST;
      end
      CCC_DONE:
      begin
        nxt_r.stat = `CCC_STAT_DONE; // RULE_10 RULE_13
      end
      default:
      begin
      end
    endcase
    nxt_r.vtarget = (r_ff.vreg > `CCC_VREG_MAX) ? `CCC_VREG_MAX : r_ff.vreg; // RULE_11
    // Supplement is an analog path; here only the rail source is reported.
    nxt_r.sys_from_bat = (!in_valid && r_ff.s2.bat_above_depl)
      || r_ff.s2.supplement_act; // RULE_18 RULE_19
    nxt_r.expired = (r_ff.expired || (nxt_r.state == CCC_FAULT)) && enabled;
    if (WR)
    begin
      if (ADDR == `CCC_ADDR_CTRL)
      begin
        nxt_r.ctrl = {4'h0, WDATA[3:0]};
      end
      else if (ADDR == `CCC_ADDR_FAST_CHARGE_CURRENT_FIELD)
      begin
        nxt_r.fast_charge_current_field = WDATA; // RULE_12
      end
      else if (ADDR == `CCC_ADDR_IPRE)
      begin
        nxt_r.ipre = WDATA;
      end
      else if (ADDR == `CCC_ADDR_VREG)
      begin
        nxt_r.vreg = WDATA;
      end
      else if (ADDR == `CCC_ADDR_TMR)
      begin
        nxt_r.tmr_limit = {WDATA, 8'h00};
      end
    end
    nxt_r.rdata = 8'h00;
    if (RD)
    begin
      if (ADDR == `CCC_ADDR_CTRL)
      begin
        nxt_r.rdata = r_ff.ctrl;
      end
      else if (ADDR == `CCC_ADDR_FAST_CHARGE_CURRENT_FIELD)
      begin
        nxt_r.rdata = r_ff.fast_charge_current_field;
      end
      else if (ADDR == `CCC_ADDR_IPRE)
      begin
        nxt_r.rdata = r_ff.ipre;
      end
      else if (ADDR == `CCC_ADDR_VREG)
      begin
        nxt_r.rdata = r_ff.vreg;
      end
      else if (ADDR == `CCC_ADDR_STAT)
      begin
        nxt_r.rdata = {4'h0, r_ff.expired, r_ff.fet_on, r_ff.stat};
      end
      else if (ADDR == `CCC_ADDR_TMR)
      begin
        nxt_r.rdata = r_ff.tmr_limit[15:8];
      end
    end
    nxt_r.tmr_tick = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      r_ff <= '0;
      r_ff.state <= CCC_IDLE;
      r_ff.ce_n_s1 <= 1'b1;
      r_ff.ce_n_s2 <= 1'b1;
      r_ff.ctrl <= `CCC_CTRL_RST;
      r_ff.fast_charge_current_field <= `CCC_FAST_CHARGE_CURRENT_FIELD_RST;
      r_ff.ipre <= `CCC_IPRE_RST;
      r_ff.vreg <= `CCC_VREG_RST;
      r_ff.vtarget <= `CCC_VREG_RST;
      r_ff.tmr_limit <= `CCC_TMR_RST;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign RDATA = r_ff.rdata;
  assign BATTERY_SWITCH = r_ff.fet_on;
  assign CURRENT_SELECT = r_ff.sel;
  assign CURRENT_TARGET = r_ff.itarget;
  assign VOLTAGE_TARGET = r_ff.vtarget;
  assign LOOPS_ENABLE = r_ff.fet_on; // RULE_20
  assign TIMER_RUN = r_ff.tmr_run;
  assign CHARGE_STATE = r_ff.stat;
  assign SYSTEM_FROM_BATTERY = r_ff.sys_from_bat;

  AST_DISABLE_OPENS: assert property (@(posedge CLK) disable iff (RESET)
    (r_ff.ctrl[0] || r_ff.ce_n_s2) |=> !BATTERY_SWITCH) // RULE_02
    else $error("switch on while disabled");
  AST_INVALID_OPENS: assert property (@(posedge CLK) disable iff (RESET)
    !in_valid |=> !BATTERY_SWITCH) // RULE_01
    else $error("switch on with bad input");
  AST_TRICKLE_SEL: assert property (@(posedge CLK) disable iff (RESET)
    (r_ff.state == CCC_TRICKLE) |-> CURRENT_SELECT == `CCC_SEL_TRICKLE) // RULE_03
    else $error("trickle select wrong");
  AST_VCLAMP: assert property (@(posedge CLK) disable iff (RESET)
    $past(r_ff.vreg) > `CCC_VREG_MAX |-> VOLTAGE_TARGET == `CCC_VREG_MAX) // RULE_11
    else $error("voltage not clamped");
  AST_DONE_OFF: assert property (@(posedge CLK) disable iff (RESET)
    (r_ff.state == CCC_DONE) |-> !BATTERY_SWITCH && CHARGE_STATE == `CCC_STAT_DONE) // RULE_13
    else $error("done state wrong");
  AST_DONE_FROM_CV: assert property (@(posedge CLK) disable iff (RESET)
    (r_ff.state == CCC_DONE) && $past(r_ff.state) != CCC_DONE |-> $past(r_ff.state) == CCC_CV) // RULE_14
    else $error("done not from cv");
  AST_NO_TERM_LIMIT: assert property (@(posedge CLK) disable iff (RESET)
    (r_ff.state == CCC_CV) && (r_ff.s2.input_current_limit_loop_act || r_ff.s2.input_voltage_limit_loop_act) |=> r_ff.state != CCC_DONE) // RULE_15
    else $error("terminated under limit");
  AST_EXPIRE: assert property (@(posedge CLK) disable iff (RESET)
    (r_ff.state == CCC_FAULT) |-> !BATTERY_SWITCH) // RULE_24
    else $error("switch on after expiry");
  AST_RECHG: assert property (@(posedge CLK) disable iff (RESET)
    (r_ff.state == CCC_DONE) && enabled && r_ff.s2.bat_below_rechg |=> r_ff.state == CCC_TRICKLE ##0 r_ff.tmr_cnt == 18'h0_0000) // RULE_16
    else $error("no recharge");
  COV_DONE: cover property (@(posedge CLK) r_ff.state == CCC_DONE);
  COV_FAULT: cover property (@(posedge CLK) r_ff.state == CCC_FAULT);
  COV_CC_CV: cover property (@(posedge CLK) r_ff.state == CCC_CC ##1 r_ff.state == CCC_CV);
endmodule

// ### bench/ccc_partner.sv
`timescale 1ns/1ns
module ccc_partner (
  // Clock
  input wire logic clk,
  // Scenario controls from the bench
  input wire logic [2:0] level,
  input wire logic [2:0] in_bits,
  input wire logic [4:0] loops,
  // Charger controls from the device
  input wire logic switch_on,
  input wire logic [2:0] sel,
  // Comparator flags towards the device
  output ccc_pkg::ccc_flags_t flags
);
  import ccc_pkg::*;
  int taper;
  // The current only reaches the end level after the voltage loop has held for a while.
  always @(posedge clk)
    taper <= (switch_on && sel == 3'h4) ? taper + 1 : 0;
  always_comb
  begin
    flags = '0;
    flags.in_uvlo_ok = in_bits[0];
    flags.in_above_bat = in_bits[1];
    flags.in_below_ovp = in_bits[2];
    flags.bat_above_sc = level >= 3'h1;
    flags.bat_above_lowv = level >= 3'h2;
    flags.bat_at_reg = level == 3'h3;
    flags.bat_below_rechg = level == 3'h4;
    flags.bat_above_depl = level != 3'h0;
    // The taper is reported even while a limiting loop holds the current down.
    flags.cur_at_term = taper >= 8;
    flags.input_voltage_limit_loop_act = loops[0];
    flags.power_path_droop_loop_act = loops[1];
    flags.input_current_limit_loop_act = loops[2];
    flags.therm_act = loops[3];
    flags.supplement_act = loops[4];
  end
endmodule

// ### bench/ccc_top_tb.sv
`timescale 1ns/1ns
module ccc_top_tb;
  import ccc_pkg::*;
  logic clk, reset, ce_n, wr, rd, sw, loops_en, trun, sfb;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, tgt, vtgt;
  logic [2:0] sel, lvl, inb;
  logic [1:0] cst;
  logic [4:0] lps;
  ccc_flags_t flags;
  int num_errors, cmp_count, m_ctrl, m_fast_charge_current_field, m_ipre, v, i;
  int stat_of[7] = '{0, 1, 1, 2, 2, 3, 0};
  int sel_of[7] = '{0, 1, 2, 3, 4, 0, 0};
  logic [7:0] rst_val[7] = '{8'h01, 8'h20, 8'h04, 8'h48, 8'h00, 8'h10, 8'h00};
  ccc_top ccc_top_inst (.CLK(clk), .RESET(reset), .FLAGS(flags), .CHARGE_ENABLE_N(ce_n),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BATTERY_SWITCH(sw),
    .CURRENT_SELECT(sel), .CURRENT_TARGET(tgt), .VOLTAGE_TARGET(vtgt), .LOOPS_ENABLE(loops_en),
    .TIMER_RUN(trun), .CHARGE_STATE(cst), .SYSTEM_FROM_BATTERY(sfb));
  ccc_partner ccc_partner_inst (.clk(clk), .level(lvl), .in_bits(inb), .loops(lps),
    .switch_on(sw), .sel(sel), .flags(flags));
  always #20 clk = ~clk;
  task automatic print_verdict();
    $display("errors %0d of %0d checks", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask
  // Expected outputs for a model state: idle, trickle, pre, cc, cv, done, fault.
  task automatic chk_out(input int st);
    int t;
    t = st == 1 ? ((m_ctrl & 2) != 0 ? 8 : 1) :
      st == 2 ? ((m_ctrl & 8) != 0 ? m_fast_charge_current_field * 51 / 256 : m_ipre) : m_fast_charge_current_field;
    chk("switch", st >= 1 && st <= 4, sw);
    chk("loops", st >= 1 && st <= 4, loops_en);
    chk("timer_run", st >= 1 && st <= 4, trun);
    chk("select", 16'(sel_of[st]), sel);
    chk("state", 16'(stat_of[st]), cst);
    if (st >= 1 && st <= 3)
      chk("target", 16'(t), tgt);
  endtask
  task automatic wait_done();
    for (int k = 0; k < 80 && cst !== 2'h3; k++)
      settle(1);
    if (cst !== 2'h3)
    begin
      num_errors++;
      print_verdict();
    end
  endtask
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    ce_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    lvl = 3'h1;
    inb = 3'h7;
    lps = 5'h00;
    m_ctrl = 1;
    v = $urandom(17681);
    settle(2);
    reset <= 1'b0;
    settle(1);
    chk("vtarget", 16'h0048, vtgt);
    chk_out(0);
    for (i = 0; i < 7; i++)
      rreg(i == 6 ? 4'hf : 4'(i), rst_val[i]);
    @(posedge clk);
    ce_n <= 1'b0;
    settle(6);
    chk_out(0);
    wreg(4'h0, 8'hf0);
    m_ctrl = 0;
    rreg(4'h0, 8'h00);
    @(posedge clk);
    lvl <= 3'h0;
    settle(6);
    chk_out(1);
    wreg(4'h0, 8'h02);
    m_ctrl = 2;
    settle(6);
    chk_out(1);
    @(posedge clk);
    ce_n <= 1'b1;
    settle(6);
    chk_out(0);
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk);
      ce_n <= 1'b0;
      inb <= 3'h7 ^ 3'(1 << i);
      settle(6);
      chk_out(0);
    end
    m_fast_charge_current_field = $urandom_range(255, 1);
    m_ipre = $urandom_range(255, 1);
    wreg(4'h1, 8'(m_fast_charge_current_field));
    wreg(4'h2, 8'(m_ipre));
    @(posedge clk);
    inb <= 3'h7;
    lvl <= 3'h1;
    settle(6);
    chk_out(2);
    wreg(4'h0, 8'h0a);
    m_ctrl = 10;
    settle(6);
    chk_out(2);
    wreg(4'h0, 8'h02);
    m_ctrl = 2;
    @(posedge clk);
    lvl <= 3'h2;
    settle(6);
    chk_out(3);
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk);
      lps <= 5'(1 << i);
      lvl <= 3'h3;
      settle(20);
      chk_out(4);
      chk("sys_bat", i == 4, sfb);
    end
    @(posedge clk);
    lps <= 5'h00;
    wait_done();
    chk_out(5);
    rreg(4'h4, 8'h03);
    @(posedge clk);
    lvl <= 3'h4;
    settle(8);
    chk_out(3);
    @(posedge clk);
    lvl <= 3'h2;
    inb <= 3'h0;
    settle(6);
    chk_out(0);
    chk("sys_bat", 1'b1, sfb);
    @(posedge clk);
    lvl <= 3'h0;
    settle(6);
    chk("sys_bat", 1'b0, sfb);
    for (i = 0; i < 5; i++)
    begin
      v = i == 4 ? 255 : i == 0 ? $urandom_range(255, 0) : 113 + i;
      wreg(4'h3, 8'(v));
      settle(3);
      chk("vtarget", 16'(v > 115 ? 115 : v), vtgt);
      rreg(4'h3, 8'(v));
    end
    wreg(4'h5, 8'h01);
    for (i = 0; i < 2; i++)
    begin
      wreg(4'h0, 8'(2 + 4 * i));
      m_ctrl = 2 + 4 * i;
      @(posedge clk);
      ce_n <= 1'b1;
      inb <= 3'h7;
      lvl <= 3'h1;
      lps <= 5'(i);
      settle(6);
      @(posedge clk);
      ce_n <= 1'b0;
      settle(56 + 54 * i);
      chk_out(2);
      settle(20 + 10 * i);
      chk_out(6);
      rreg(4'h4, 8'h08);
    end
    print_verdict();
  end
endmodule
